// file: peak_and_event_status_regs.sv
// Summary of operation
// - Peak voltage magnitude held in bits 23:0 of the peak register.
// - Bits 24, 25, 26 mark phase A, B or C as peak source.
// - Peak register bits 31:27 always read zero.
// - Zero-padded 24-bit values read as 32 bits, top byte zero.
// - Signed 24-bit values read as 32 bits, sign copied to top byte.
// - Unsigned 10-bit values read as 16 bits, top six bits zero.
// - Status bit 0 sets when any total active energy bit 30 changes.
// - Status bit 1 sets when any fundamental active energy bit 30 changes.
// - Status bit 2 sets when any total reactive energy bit 30 changes.
// - Status bit 3 sets on fundamental reactive energy bit 30 change.
// - Status bit 4 sets when any apparent energy bit 30 changes.
// - Status bit 5 sets when line-cycle integration completes.
// - Bits 6-8 set on phase active power sign change; select picks source.
// - Bits 10-12 set on phase reactive sign change; select picks source.
// - Bits 9, 13, 18 set when pulse path sums one to three change sign.
// - Sign register: active 0-2, reactive 4-6, sums at 3, 7, 8.
// - Bits 14-16 set on falling edge of pulse outputs one to three.
// - Pulse flags set even while the pulse pin is disabled.
// - Pulse power select fields at bits 2:0, 5:3 and 8:6.
// - Status bit 17 sets when the periodic DSP cycle completes.
// - Status bits 31:19 read zero; all flags reset to zero.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module peak_and_event_status_regs (
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  input  wire logic [meter_status_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                             awvalid,
  output logic                                  awready,
  input  wire logic [31:0]                      wdata,
  input  wire logic [3:0]                       wstrb,
  input  wire logic                             wvalid,
  output logic                                  wready,
  output logic [1:0]                            bresp,
  output logic                                  bvalid,
  input  wire logic                             bready,
  input  wire logic [meter_status_pkg::ADDR_W-1:0] araddr,
  input  wire logic                             arvalid,
  output logic                                  arready,
  output logic [31:0]                           rdata,
  output logic [1:0]                            rresp,
  output logic                                  rvalid,
  input  wire logic                             rready,
  input  wire meter_status_pkg::dsp_feed_t      feed,
  output logic                                  pulse_out_one_n,
  output logic                                  pulse_out_two_n,
  output logic                                  pulse_out_three_n,
  output logic [2:0]                            pulse_one_power_select,
  output logic [2:0]                            pulse_two_power_select,
  output logic [2:0]                            pulse_three_power_select,
  output logic                                  active_sign_source_select,
  output logic                                  reactive_sign_source_select
);
  import meter_status_pkg::*;

  state_t          s_reg;
  state_t          s_next;
  logic            wr_fire;
  logic [31:0]     wmask;
  logic [15:0]     wr_idx;
  logic [15:0]     rd_idx;
  logic [ST_W-1:0] clr_mask;
  logic [ST_W-1:0] ev_set;
  logic [8:0]      sign_now;
  logic [8:0]      sign_diff;
  logic [2:0]      pulse_fall;
  logic [4:0]      half_flip;
  logic [23:0]     peak_base;
  logic            peak_load;
  logic [31:0]     rd_value;
  logic            rd_hit;

  assign awready = !s_reg.aw_have;
  assign wready  = !s_reg.w_have;
  assign arready = !s_reg.rvalid;
  assign bvalid  = s_reg.bvalid;
  assign bresp   = s_reg.bresp;
  assign rvalid  = s_reg.rvalid;
  assign rresp   = s_reg.rresp;
  assign rdata   = s_reg.rdata;

  assign pulse_out_one_n   = s_reg.pulse_pin_n[0];
  assign pulse_out_two_n   = s_reg.pulse_pin_n[1];
  assign pulse_out_three_n = s_reg.pulse_pin_n[2];
  assign pulse_one_power_select =
    s_reg.pmode[PM_SEL_ONE_LSB +: 3];
  assign pulse_two_power_select =
    s_reg.pmode[PM_SEL_TWO_LSB +: 3];
  assign pulse_three_power_select =
    s_reg.pmode[PM_SEL_THREE_LSB +: 3];
  assign active_sign_source_select   = s_reg.meas_mode[MM_ACT_SEL];
  assign reactive_sign_source_select = s_reg.meas_mode[MM_REACT_SEL];

  // Write side: address and data may arrive in either order
  assign wr_fire = s_reg.aw_have && s_reg.w_have && !s_reg.bvalid;
  assign wr_idx  = s_reg.aw_addr[ADDR_W-1:2];
  assign rd_idx  = araddr[ADDR_W-1:2];
  assign wmask   = {{8{s_reg.w_strb[3]}}, {8{s_reg.w_strb[2]}},
                    {8{s_reg.w_strb[1]}}, {8{s_reg.w_strb[0]}}};

  // Only enabled byte lanes clear flags
  assign clr_mask = (wr_fire && wr_idx == IDX_STATUS) ?
                    (s_reg.w_data[ST_W-1:0] & wmask[ST_W-1:0]) :
                    '0;

  // Energy half flags: one per accumulator kind, any of three phases
  for (genvar k = 0; k < 5; k++) begin : g_half
    assign half_flip[k] = |(feed.energy_bit30[3*k +: 3] ^
                            s_reg.bit30_prev[3*k +: 3]);
  end

  // Sign sources follow the measurement mode selects
  // One process drives the whole word, so it has a single driver
  always_comb begin
    sign_now = '0;
    sign_now[SG_ACT_LSB +: 3] = s_reg.meas_mode[MM_ACT_SEL] ?
      feed.signs.act_fund : feed.signs.act_total;
    sign_now[SG_REACT_LSB +: 3] = s_reg.meas_mode[MM_REACT_SEL] ?
      feed.signs.react_fund : feed.signs.react_total;
    sign_now[SG_SUM_ONE]   = feed.signs.sum[0];
    sign_now[SG_SUM_TWO]   = feed.signs.sum[1];
    sign_now[SG_SUM_THREE] = feed.signs.sum[2];
  end
  assign sign_diff = sign_now ^ s_reg.sign;

  // Raw level, before the disable gate, so flags still fire
  assign pulse_fall = s_reg.pulse_prev & ~feed.pulse_level;

  always_comb begin
    ev_set = '0;
    ev_set[ST_ENERGY_LSB +: 5] = half_flip;
    ev_set[ST_LINE_DONE] = feed.line_cycle_done;
    ev_set[ST_ACT_LSB +: 3] = sign_diff[SG_ACT_LSB +: 3];
    ev_set[ST_REACT_LSB +: 3] = sign_diff[SG_REACT_LSB +: 3];
    ev_set[ST_SUM_ONE]   = sign_diff[SG_SUM_ONE];
    ev_set[ST_SUM_TWO]   = sign_diff[SG_SUM_TWO];
    ev_set[ST_SUM_THREE] = sign_diff[SG_SUM_THREE];
    ev_set[ST_PULSE_LSB +: 3] = pulse_fall;
    ev_set[ST_DSP_DONE] = feed.dsp_cycle_done;
  end

  // A restart starts the search afresh from zero
  assign peak_base = feed.peak_restart ? 24'h000000 : s_reg.peak_mag;
  assign peak_load = feed.sample.valid &&
                     (feed.sample.magnitude > peak_base);

  always_comb begin
    rd_hit   = 1'b1;
    rd_value = 32'h00000000;
    unique case (rd_idx)
      IDX_PEAK: begin
        rd_value = pad24(s_reg.peak_mag);
        rd_value[PEAK_PHASE_LSB +: 3] = s_reg.peak_phase;
        rd_value[31:PEAK_ZERO_LSB] = '0;
      end
      IDX_STATUS: begin
        rd_value[ST_W-1:0] = s_reg.status;
      end
      IDX_MEAS_MODE: begin
        rd_value[1:0] = s_reg.meas_mode;
      end
      IDX_PMODE: begin
        rd_value[11:0] = s_reg.pmode;
      end
      IDX_SIGN: begin
        rd_value[8:0] = s_reg.sign;
      end
      IDX_SAMPLE: begin
        rd_value = sext24(s_reg.last_sample);
      end
      IDX_DSPCNT: begin
        rd_value[15:0] = pad10(s_reg.dsp_count);
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    s_next = s_reg;
    if (awvalid && awready) begin
      s_next.aw_have = 1'b1;
      s_next.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      s_next.w_have = 1'b1;
      s_next.w_data = wdata;
      s_next.w_strb = wstrb;
    end
    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
    end
    if (wr_fire) begin
      s_next.aw_have = 1'b0;
      s_next.w_have  = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = RESP_OKAY;
      unique case (wr_idx)
        IDX_MEAS_MODE: begin
          s_next.meas_mode = (s_reg.meas_mode & ~wmask[1:0]) |
                             (s_reg.w_data[1:0] & wmask[1:0]);
        end
        IDX_PMODE: begin
          s_next.pmode = (s_reg.pmode & ~wmask[11:0]) |
                         (s_reg.w_data[11:0] & wmask[11:0]);
        end
        // Status clears through clr_mask; read-only words accept and ignore the write
        IDX_STATUS, IDX_PEAK, IDX_SIGN, IDX_SAMPLE, IDX_DSPCNT: begin
        end
        default: begin
          s_next.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      s_next.rvalid = 1'b1;
      s_next.rdata  = rd_value;
      s_next.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end

    // A new event beats a clear in the same cycle
    s_next.status = (s_reg.status & ~clr_mask) | ev_set;

    if (peak_load) begin
      s_next.peak_mag   = feed.sample.magnitude;
      s_next.peak_phase = feed.sample.phase;
    end else if (feed.peak_restart) begin
      s_next.peak_mag   = '0;
      s_next.peak_phase = '0;
    end
    if (feed.sample.valid) begin
      s_next.last_sample = feed.sample.value;
    end

    s_next.sign        = sign_now;
    s_next.bit30_prev  = feed.energy_bit30;
    s_next.pulse_prev  = feed.pulse_level;
    // Disabled pins idle high
    s_next.pulse_pin_n = feed.pulse_level |
                         s_reg.pmode[PM_DIS_LSB +: 3];
    if (feed.dsp_cycle_done) begin
      s_next.dsp_count = s_reg.dsp_count + 10'h001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= STATE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  chk_peak_update: assert property (
    @(posedge aclk) disable iff (!aresetn)
    peak_load |=> s_reg.peak_mag == $past(feed.sample.magnitude) &&
                  s_reg.peak_phase == $past(feed.sample.phase))
    else $error("peak magnitude and phase not loaded together");

  chk_peak_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !peak_load && !feed.peak_restart
    |=> $stable(s_reg.peak_mag) && $stable(s_reg.peak_phase))
    else $error("peak changed without a larger sample");

  chk_peak_top_zero: assert property (
    @(posedge aclk) disable iff (!aresetn)
    arvalid && arready && rd_idx == IDX_PEAK
    |=> rvalid && rdata[31:27] == 5'h00)
    else $error("peak register top bits not zero");

  chk_status_resv: assert property (
    @(posedge aclk) disable iff (!aresetn)
    arvalid && arready && rd_idx == IDX_STATUS
    |=> rdata[31:19] == 13'h0000 &&
        rdata[18:0] == $past(s_reg.status))
    else $error("status readback wrong");

  chk_energy_flag: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (feed.energy_bit30[2:0] != $past(feed.energy_bit30[2:0]))
    |=> s_reg.status[0])
    else $error("active energy half flag missed");

  chk_fund_energy: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (feed.energy_bit30[5:3] != $past(feed.energy_bit30[5:3]))
    |=> s_reg.status[1])
    else $error("fundamental active energy half flag missed");

  chk_react_energy: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (feed.energy_bit30[8:6] != $past(feed.energy_bit30[8:6]))
    |=> s_reg.status[2])
    else $error("total reactive energy half flag missed");

  chk_fund_react_energy: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (feed.energy_bit30[11:9] != $past(feed.energy_bit30[11:9]))
    |=> s_reg.status[3])
    else $error("fundamental reactive energy half flag missed");

  chk_apparent_energy: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (feed.energy_bit30[14:12] != $past(feed.energy_bit30[14:12]))
    |=> s_reg.status[4])
    else $error("apparent energy half flag missed");

  chk_flag_sticky: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ##1 ((s_reg.status & $past(s_reg.status & ~clr_mask)) ==
         $past(s_reg.status & ~clr_mask)))
    else $error("status flag dropped without clear");

  chk_pulse_flag: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $fell(feed.pulse_level[0]) |=> s_reg.status[14])
    else $error("pulse one falling edge not flagged");

  chk_pulse_two_flag: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $fell(feed.pulse_level[1]) |=> s_reg.status[15])
    else $error("pulse two falling edge not flagged");

  chk_pulse_three_flag: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $fell(feed.pulse_level[2]) |=> s_reg.status[16])
    else $error("pulse three falling edge not flagged");

  chk_dsp_flag: assert property (
    @(posedge aclk) disable iff (!aresetn)
    feed.dsp_cycle_done |=> s_reg.status[17] ##1 1'b1)
    else $error("dsp cycle flag missed");

  chk_act_sign: assert property (
    @(posedge aclk) disable iff (!aresetn)
    sign_diff[2:0] != 3'h0
    |=> (s_reg.status[8:6] & $past(sign_diff[2:0])) ==
        $past(sign_diff[2:0]))
    else $error("active sign change not flagged");

  chk_react_sign: assert property (
    @(posedge aclk) disable iff (!aresetn)
    sign_diff[6:4] != 3'h0
    |=> (s_reg.status[12:10] & $past(sign_diff[6:4])) ==
        $past(sign_diff[6:4]))
    else $error("reactive sign change not flagged");

  chk_sum_sign: assert property (
    @(posedge aclk) disable iff (!aresetn)
    sign_diff[8] |=> s_reg.status[18] && s_reg.sign[8] ==
                     $past(feed.signs.sum[2]))
    else $error("sum three sign change not flagged");

  chk_sum_one_sign: assert property (
    @(posedge aclk) disable iff (!aresetn)
    sign_diff[3] |=> s_reg.status[9] && s_reg.sign[3] ==
                     $past(feed.signs.sum[0]))
    else $error("sum one sign change not flagged");

  chk_sum_two_sign: assert property (
    @(posedge aclk) disable iff (!aresetn)
    sign_diff[7] |=> s_reg.status[13] && s_reg.sign[7] ==
                     $past(feed.signs.sum[1]))
    else $error("sum two sign change not flagged");

  chk_line_done: assert property (
    @(posedge aclk) disable iff (!aresetn)
    feed.line_cycle_done |=> s_reg.status[5])
    else $error("line cycle flag missed");

  chk_pulse_off: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_reg.pmode[9] && $stable(s_reg.pmode[9]) |-> pulse_out_one_n)
    else $error("disabled pulse pin not idle high");

endmodule // peak_and_event_status_regs
`default_nettype wire

// file: meter_status_pkg.sv
`default_nettype none
package meter_status_pkg;

  localparam int ADDR_W = 18;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_PEAK      = 16'hE501;
  localparam logic [15:0] IDX_STATUS    = 16'hE502;
  localparam logic [15:0] IDX_MEAS_MODE = 16'hE600;
  localparam logic [15:0] IDX_PMODE     = 16'hE601;
  localparam logic [15:0] IDX_SIGN      = 16'hE602;
  localparam logic [15:0] IDX_SAMPLE    = 16'hE603;
  localparam logic [15:0] IDX_DSPCNT    = 16'hE604;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Peak register layout
  localparam int PEAK_PHASE_LSB = 24;
  localparam int PEAK_ZERO_LSB  = 27;

  // Event status bit positions
  localparam int ST_ENERGY_LSB = 0;
  localparam int ST_LINE_DONE  = 5;
  localparam int ST_ACT_LSB    = 6;
  localparam int ST_SUM_ONE    = 9;
  localparam int ST_REACT_LSB  = 10;
  localparam int ST_SUM_TWO    = 13;
  localparam int ST_PULSE_LSB  = 14;
  localparam int ST_DSP_DONE   = 17;
  localparam int ST_SUM_THREE  = 18;
  localparam int ST_W          = 19;

  // Power sign register layout
  localparam int SG_ACT_LSB   = 0;
  localparam int SG_SUM_ONE   = 3;
  localparam int SG_REACT_LSB = 4;
  localparam int SG_SUM_TWO   = 7;
  localparam int SG_SUM_THREE = 8;

  // Pulse mode register layout
  localparam int PM_SEL_ONE_LSB   = 0;
  localparam int PM_SEL_TWO_LSB   = 3;
  localparam int PM_SEL_THREE_LSB = 6;
  localparam int PM_DIS_LSB       = 9;

  // Measurement mode register layout
  localparam int MM_ACT_SEL   = 0;
  localparam int MM_REACT_SEL = 1;

  localparam logic [1:0]  MEAS_MODE_RESET = 2'h0;
  localparam logic [11:0] PMODE_RESET     = 12'h000;
  localparam logic [2:0]  PULSE_IDLE      = 3'h7;

  typedef struct packed {
    logic        valid;
    logic [2:0]  phase;
    logic [23:0] magnitude;
    logic [23:0] value;
  } peak_sample_t;

  typedef struct packed {
    logic [2:0] act_total;
    logic [2:0] act_fund;
    logic [2:0] react_total;
    logic [2:0] react_fund;
    logic [2:0] sum;
  } power_signs_t;

  typedef struct packed {
    peak_sample_t sample;
    logic         peak_restart;
    power_signs_t signs;
    logic [14:0]  energy_bit30;
    logic         line_cycle_done;
    logic         dsp_cycle_done;
    logic [2:0]   pulse_level;
  } dsp_feed_t;

  typedef struct packed {
    logic              aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_have;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic [23:0]       peak_mag;
    logic [2:0]        peak_phase;
    logic [23:0]       last_sample;
    logic [1:0]        meas_mode;
    logic [11:0]       pmode;
    logic [8:0]        sign;
    logic [ST_W-1:0]   status;
    logic [14:0]       bit30_prev;
    logic [2:0]        pulse_prev;
    logic [2:0]        pulse_pin_n;
    logic [9:0]        dsp_count;
  } state_t;

  localparam state_t STATE_RESET = '{
    meas_mode: MEAS_MODE_RESET, pmode: PMODE_RESET,
    pulse_prev: PULSE_IDLE, pulse_pin_n: PULSE_IDLE,
    default: '0};

  function automatic logic [31:0] pad24(input logic [23:0] x);
    return {8'h00, x};
  endfunction

  function automatic logic [31:0] sext24(input logic [23:0] x);
    return {{8{x[23]}}, x};
  endfunction

  function automatic logic [15:0] pad10(input logic [9:0] x);
    return {6'h00, x};
  endfunction

endpackage
`default_nettype wire

// file: tb_peak_and_event_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_peak_and_event_status_regs;
  import meter_status_pkg::*;

  logic              aclk      = 1'b0;
  logic              aresetn   = 1'b0;
  logic [ADDR_W-1:0] awaddr    = '0;
  logic [ADDR_W-1:0] araddr    = '0;
  logic              awvalid   = 1'b0;
  logic              wvalid    = 1'b0;
  logic              bready    = 1'b0;
  logic              arvalid   = 1'b0;
  logic              rready    = 1'b0;
  logic [31:0]       wdata     = '0;
  logic [3:0]        wstrb     = 4'hF;
  dsp_feed_t         feed      = '{pulse_level: 3'h7, default: '0};
  logic              awready;
  logic              wready;
  logic              bvalid;
  logic              arready;
  logic              rvalid;
  logic [1:0]        bresp;
  logic [1:0]        rresp;
  logic [31:0]       rdata;
  logic [2:0]        pin_n;
  logic [2:0]        sel1;
  logic [2:0]        sel2;
  logic [2:0]        sel3;
  logic              act_sel;
  logic              react_sel;
  int                bad_count = 0;
  int                cmp_count = 0;
  int                sum_sg[3] = '{SG_SUM_ONE, SG_SUM_TWO, SG_SUM_THREE};
  int                sum_st[3] = '{ST_SUM_ONE, ST_SUM_TWO, ST_SUM_THREE};

  always #50 aclk = ~aclk;

  peak_and_event_status_regs u_peak_and_event_status_regs (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .feed(feed),
    .pulse_out_one_n(pin_n[0]), .pulse_out_two_n(pin_n[1]),
    .pulse_out_three_n(pin_n[2]),
    .pulse_one_power_select(sel1), .pulse_two_power_select(sel2),
    .pulse_three_power_select(sel3),
    .active_sign_source_select(act_sel),
    .reactive_sign_source_select(react_sel)
  );

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_resp(input string name, input logic [1:0] exp,
                          input logic [1:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Handshakes are sampled at the falling edge: inputs only move at the
  // rising edge, so this equals what the slave sees, without a race
  task automatic wr(input logic [15:0] idx, input logic [31:0] d,
                    input logic [1:0] exp_resp);
    logic       a;
    logic       w;
    logic       b;
    logic [1:0] resp;
    b = 1'b0;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b) begin
      @(negedge aclk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid && bready;
      resp = bresp;
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
    end
    chk_resp($sformatf("bresp %h", idx), exp_resp, resp);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [31:0] exp,
                    input logic [1:0] exp_resp);
    logic        a;
    logic        r;
    logic [31:0] d;
    logic [1:0]  resp;
    r = 1'b0;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r) begin
      @(negedge aclk);
      a = arvalid && arready;
      r = rvalid && rready;
      d = rdata;
      resp = rresp;
      @(posedge aclk);
      if (a) arvalid <= 1'b0;
      if (r) rready <= 1'b0;
    end
    chk_resp($sformatf("rresp %h", idx), exp_resp, resp);
    chk($sformatf("rdata %h", idx), exp, d);
  endtask

  // Waits first so the flag has to outlive its one-cycle cause
  task automatic flag(input int b);
    repeat (3) @(posedge aclk);
    rd(IDX_STATUS, 32'h1 << b, RESP_OKAY);
    wr(IDX_STATUS, 32'h1 << b, RESP_OKAY);
    rd(IDX_STATUS, 32'h0, RESP_OKAY);
  endtask

  task automatic peak(input logic [2:0] ph, input logic [23:0] mag,
                      input logic [23:0] val, input logic restart);
    @(posedge aclk);
    feed.sample <= '{valid: 1'b1, phase: ph, magnitude: mag, value: val};
    feed.peak_restart <= restart;
    @(posedge aclk);
    feed.sample.valid <= 1'b0;
    feed.peak_restart <= 1'b0;
  endtask

  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    test_done();
  end

  initial begin
    logic [31:0] sg;
    sg = 32'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(IDX_PEAK, 32'h0, RESP_OKAY);
    rd(IDX_STATUS, 32'h0, RESP_OKAY);
    rd(16'h0000, 32'h0, RESP_SLVERR);
    wr(16'h0000, 32'hFFFFFFFF, RESP_SLVERR);
    wr(IDX_STATUS, 32'hFFFFFFFF, RESP_OKAY);
    rd(IDX_STATUS, 32'h0, RESP_OKAY);
    for (int k = 0; k < 5; k++) begin
      feed.energy_bit30 <= feed.energy_bit30 ^ (15'h1 << (3 * k + k % 3));
      flag(ST_ENERGY_LSB + k);
    end
    feed.line_cycle_done <= 1'b1;
    @(posedge aclk);
    feed.line_cycle_done <= 1'b0;
    flag(ST_LINE_DONE);
    repeat (3) begin
      feed.dsp_cycle_done <= 1'b1;
      @(posedge aclk);
      feed.dsp_cycle_done <= 1'b0;
      @(posedge aclk);
    end
    flag(ST_DSP_DONE);
    rd(IDX_DSPCNT, 32'h3, RESP_OKAY);
    for (int p = 0; p < 3; p++) begin
      feed.signs.act_total[p] <= 1'b1;
      flag(ST_ACT_LSB + p);
      feed.signs.react_total[p] <= 1'b1;
      flag(ST_REACT_LSB + p);
      feed.signs.sum[p] <= 1'b1;
      flag(sum_st[p]);
      sg = sg | (32'h1 << p) | (32'h1 << (SG_REACT_LSB + p));
      sg = sg | (32'h1 << sum_sg[p]);
      rd(IDX_SIGN, sg, RESP_OKAY);
    end
    // Fundamental sources move while the total ones are watched
    feed.signs.act_fund <= 3'h7;
    feed.signs.react_fund <= 3'h7;
    repeat (3) @(posedge aclk);
    rd(IDX_STATUS, 32'h0, RESP_OKAY);
    wr(IDX_MEAS_MODE, 32'h3, RESP_OKAY);
    rd(IDX_MEAS_MODE, 32'h3, RESP_OKAY);
    chk("src_sel", 32'h3, {30'h0, react_sel, act_sel});
    feed.signs.act_fund <= 3'h0;
    feed.signs.react_fund <= 3'h6;
    repeat (3) @(posedge aclk);
    rd(IDX_STATUS, 32'h0000_05C0, RESP_OKAY);
    rd(IDX_SIGN, 32'h1E8, RESP_OKAY);
    // Byte lane 0 only: bits 8 and 10 must survive the clear
    wstrb <= 4'h1;
    wr(IDX_STATUS, 32'h0000_05C0, RESP_OKAY);
    rd(IDX_STATUS, 32'h0000_0500, RESP_OKAY);
    wstrb <= 4'hF;
    wr(IDX_STATUS, 32'h0000_0500, RESP_OKAY);
    wr(IDX_PMODE, 32'hF59, RESP_OKAY);
    rd(IDX_PMODE, 32'hF59, RESP_OKAY);
    chk("pulse_sel", 32'h159, {23'h0, sel3, sel2, sel1});
    for (int p = 0; p < 3; p++) begin
      feed.pulse_level[p] <= 1'b0;
      repeat (2) @(posedge aclk);
      chk("pulse_pins", 32'h7, {29'h0, pin_n});
      feed.pulse_level[p] <= 1'b1;
      flag(ST_PULSE_LSB + p);
    end
    wr(IDX_PMODE, 32'h0, RESP_OKAY);
    feed.pulse_level[1] <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("pulse_pins", 32'h5, {29'h0, pin_n});
    feed.pulse_level[1] <= 1'b1;
    flag(ST_PULSE_LSB + 1);
    peak(3'b010, 24'h123456, 24'h800001, 1'b0);
    rd(IDX_PEAK, 32'h0212_3456, RESP_OKAY);
    rd(IDX_SAMPLE, 32'hFF80_0001, RESP_OKAY);
    peak(3'b001, 24'h000010, 24'h000010, 1'b0);
    rd(IDX_PEAK, 32'h0212_3456, RESP_OKAY);
    peak(3'b100, 24'hFFFFFF, 24'h7FFFFF, 1'b0);
    rd(IDX_PEAK, 32'h04FF_FFFF, RESP_OKAY);
    wr(IDX_PEAK, 32'h0, RESP_OKAY);
    rd(IDX_PEAK, 32'h04FF_FFFF, RESP_OKAY);
    peak(3'b001, 24'h000005, 24'h000005, 1'b1);
    rd(IDX_PEAK, 32'h0100_0005, RESP_OKAY);
    rd(IDX_SAMPLE, 32'h0000_0005, RESP_OKAY);
    rd(IDX_STATUS, 32'h0, RESP_OKAY);
    test_done();
  end
endmodule // tb_peak_and_event_status_regs
`default_nettype wire
